// [trbg_pkg.sv]
// Purpose: Shared constants and types for the true random byte generator.
// Assumes: 100 MHz clock, Avalon-MM register access with 32-bit data.
// Notes:   Byte offsets equal the printed offsets.
package trbg_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] TRBG_OFS_START    = 12'h000;
    localparam logic [11:0] TRBG_OFS_STOP     = 12'h004;
    localparam logic [11:0] TRBG_OFS_FLAG     = 12'h100;
    localparam logic [11:0] TRBG_OFS_SHORT    = 12'h200;
    localparam logic [11:0] TRBG_OFS_IRQ_SET  = 12'h304;
    localparam logic [11:0] TRBG_OFS_IRQ_CLR  = 12'h308;
    localparam logic [11:0] TRBG_OFS_CONFIG   = 12'h504;
    localparam logic [11:0] TRBG_OFS_VALUE    = 12'h508;

    localparam int          TRBG_BIT_LSB      = 0;
    localparam logic [7:0]  TRBG_VALUE_RST    = 8'h00;
    localparam logic [31:0] TRBG_READ_ZERO    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int TRBG_CLK_MHZ      = 100;
    localparam int TRBG_START_US     = 128;
    localparam int TRBG_RAW_BYTE_US  = 30;
    localparam int TRBG_BC_BYTE_US   = 120;
    localparam int TRBG_START_CYC    = TRBG_START_US * TRBG_CLK_MHZ;
    localparam int TRBG_RAW_BIT_CYC  = (TRBG_RAW_BYTE_US * TRBG_CLK_MHZ) / 8;
    localparam int TRBG_BC_PAIR_CYC  = (TRBG_BC_BYTE_US * TRBG_CLK_MHZ) / 32;

    typedef enum logic [1:0] {
        TRBG_IDLE  = 2'b00,
        TRBG_WARM  = 2'b01,
        TRBG_RUN   = 2'b10
    } trbg_state_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [11:0] address;
        logic [31:0] writedata;
    } trbg_req_t;

endpackage

// [trbg_top.sv]
// Purpose: True random byte generator with Avalon-MM registers.
// Assumes: Noise bit arrives asynchronously on noise_i.
// Notes:   Per-byte time depends on noise sampling and bias rejection.
`timescale 1ns/1ns

// Function
// - start task runs, stop task halts
// - bytes produced continuously, written when complete
// - one ready event per written byte
// - bits shift into eight-bit collector
// - config bit0 enables bias correction
// - byte time fixed in raw mode, varies with bias correction
// - start/stop by writing one at 0x000/0x004
// - event flag at 0x100 readable/writable
// - shortcut bit stops on each event
// - read-only output byte at 0x508
// - one-time startup delay after start
// - raw byte typically 30 us
// - corrected byte typically 120 us
module trbg_top
    import trbg_pkg::*;
#(
    parameter int START_CYC    = TRBG_START_CYC,
    parameter int RAW_BIT_CYC  = TRBG_RAW_BIT_CYC,
    parameter int BC_PAIR_CYC  = TRBG_BC_PAIR_CYC
) (
    input  wire logic        clk_i,          // 100 MHz clock
    input  wire logic        rst_n_i,        // Async reset, active low
    input  wire logic        noise_i,        // Asynchronous noise bit
    input  wire logic [11:0] avs_address_i,  // Byte address
    input  wire logic        avs_read_i,     // Read request
    input  wire logic        avs_write_i,    // Write request
    input  wire logic [31:0] avs_writedata_i,// Write data
    input  wire logic [3:0]  avs_byteenable_i,// Byte enables
    output logic [31:0]      avs_readdata_o, // Read data
    output logic             avs_waitrequest_o,// Wait request
    output logic             irq_o           // Level interrupt
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    trbg_req_t req;
    assign req = '{read: avs_read_i, write: avs_write_i, address: avs_address_i,
                   writedata: avs_writedata_i};

    // One wait cycle per access keeps read data registered
    logic ack_q;
    assign avs_waitrequest_o = (req.read | req.write) & ~ack_q;
    wire   acc_done = (req.read | req.write) & ack_q;
    wire   wr_en    = req.write & ack_q & avs_byteenable_i[0];
    wire   wbit     = req.writedata[TRBG_BIT_LSB];

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // One compare for every offset keeps the write strobes consistent
    // when the map changes
    function automatic logic trbg_at(input logic [11:0] addr, input logic [11:0] ofs);
        return (addr == ofs);
    endfunction

    wire   wr_start = wr_en & trbg_at(req.address, TRBG_OFS_START) & wbit;
    wire   wr_stop  = wr_en & trbg_at(req.address, TRBG_OFS_STOP) & wbit;
    wire   wr_flag  = wr_en & trbg_at(req.address, TRBG_OFS_FLAG);
    wire   wr_short = wr_en & trbg_at(req.address, TRBG_OFS_SHORT);
    wire   wr_iset  = wr_en & trbg_at(req.address, TRBG_OFS_IRQ_SET) & wbit;
    wire   wr_iclr  = wr_en & trbg_at(req.address, TRBG_OFS_IRQ_CLR) & wbit;
    wire   wr_cfg   = wr_en & trbg_at(req.address, TRBG_OFS_CONFIG);

    // ------------------------------------------------------------------
    // Noise synchroniser: three stages, change accepted when 2 and 3 agree
    // ------------------------------------------------------------------
    logic [2:0] sync_q;
    logic       noise_q;
    wire        noise_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : noise_q;

    // ------------------------------------------------------------------
    // Generator state
    // ------------------------------------------------------------------
    trbg_state_t state_q, state_d;
    logic [15:0] cnt_q;
    logic [2:0]  nbits_q;
    logic [7:0]  shift_q;
    logic [7:0]  value_q;
    logic        have_first_q, first_bit_q;
    logic        flag_q, short_q, ien_q, cfg_q;

    // Terminal count of an n-cycle period; the cut to counter width is
    // deliberate, so periods must stay below 65536 cycles
    function automatic logic [15:0] trbg_last(input int n);
        return 16'(n - 1);
    endfunction

    wire tick_raw = (cnt_q >= trbg_last(RAW_BIT_CYC));
    wire tick_bc  = (cnt_q >= trbg_last(BC_PAIR_CYC));
    wire warm_end = (cnt_q >= trbg_last(START_CYC));
    wire tick     = (state_q == TRBG_RUN) & (cfg_q ? tick_bc : tick_raw);

    // Bias correction: take bit pairs, keep first bit only if pair differs
    wire pair_done = tick & cfg_q & have_first_q;
    wire bit_take  = tick & (~cfg_q | (pair_done & (first_bit_q != noise_q)));
    wire byte_done = bit_take & (nbits_q == 3'd7);
    wire [7:0] next_byte = {shift_q[6:0], cfg_q ? first_bit_q : noise_q};

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            TRBG_IDLE: begin
                if (wr_start) begin
                    state_d = TRBG_WARM;
                end
            end
            TRBG_WARM: begin
                // A stop abandons the warm-up; the next start pays it again
                if (wr_stop) begin
                    state_d = TRBG_IDLE;
                end else if (warm_end) begin
                    state_d = TRBG_RUN;
                end
            end
            TRBG_RUN: begin
                if (wr_stop | (byte_done & short_q)) begin
                    state_d = TRBG_IDLE;
                end
            end
            default: begin
                state_d = TRBG_IDLE;
            end
        endcase
    end

    wire restart  = (state_d != state_q) | (state_q == TRBG_IDLE);
    wire cnt_wrap = tick | restart;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= TRBG_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // The period counter restarts on every state change, so the warm-up
    // is paid once per start and never between bytes of one run
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_wrap ? 16'h0000 : cnt_q + 16'h0001;
        end
    end

    // Synchroniser stages shift on every edge; only the last two are compared
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_q  <= 3'b000;
            noise_q <= 1'b0;
        end else begin
            sync_q  <= {sync_q[1:0], noise_i};
            noise_q <= noise_d;
        end
    end

    // ------------------------------------------------------------------
    // Bit collection
    // ------------------------------------------------------------------
    // The first bit of a pair waits here for its partner
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            have_first_q <= 1'b0;
            first_bit_q  <= 1'b0;
        end else if (restart) begin
            have_first_q <= 1'b0;
        end else if (tick & cfg_q) begin
            have_first_q <= ~have_first_q;
            if (!have_first_q) begin
                first_bit_q <= noise_q;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nbits_q <= 3'd0;
            shift_q <= TRBG_VALUE_RST;
        end else if (restart) begin
            nbits_q <= 3'd0;
        end else if (bit_take) begin
            shift_q <= next_byte;
            nbits_q <= nbits_q + 3'd1;
        end
    end

    // ------------------------------------------------------------------
    // Output byte
    // ------------------------------------------------------------------
    // A new byte overwrites the old one at once; software has until the
    // next ready event to fetch it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_q <= TRBG_VALUE_RST;
        end else if (byte_done) begin
            value_q <= next_byte;
        end
    end

    // ------------------------------------------------------------------
    // Registers and interrupt
    // ------------------------------------------------------------------
    // Bus handshake: a request is answered one cycle after it rises
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (req.read | req.write) & ~ack_q;
        end
    end

    // Set wins over a same-cycle software write, so no event is lost
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
        end else if (byte_done) begin
            flag_q <= 1'b1;
        end else if (wr_flag) begin
            flag_q <= wbit;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            short_q <= 1'b0;
        end else if (wr_short) begin
            short_q <= wbit;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ien_q <= 1'b0;
        end else if (wr_iset) begin
            ien_q <= 1'b1;
        end else if (wr_iclr) begin
            ien_q <= 1'b0;
        end
    end

    // A mode change mid-run acts at the next tick; a byte in progress
    // may then be built from both modes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= 1'b0;
        end else if (wr_cfg) begin
            cfg_q <= wbit;
        end
    end

    assign irq_o = flag_q & ien_q;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [31:0] rdata_q;
    logic [31:0] rsel;
    always_comb begin
        rsel = TRBG_READ_ZERO;
        case (req.address)
            TRBG_OFS_FLAG:    rsel = {31'd0, flag_q};
            TRBG_OFS_SHORT:   rsel = {31'd0, short_q};
            TRBG_OFS_IRQ_SET,
            TRBG_OFS_IRQ_CLR: rsel = {31'd0, ien_q};
            TRBG_OFS_CONFIG:  rsel = {31'd0, cfg_q};
            TRBG_OFS_VALUE:   rsel = {24'd0, value_q};
            default:          rsel = TRBG_READ_ZERO;
        endcase
    end

    // Read data is captured in the wait cycle and stands until the next read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= TRBG_READ_ZERO;
        end else if (req.read & ~ack_q) begin
            rdata_q <= rsel;
        end
    end
    assign avs_readdata_o = rdata_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    start_runs_a: assert property ((state_q == TRBG_IDLE) && wr_start |=> state_q == TRBG_WARM)
        else $error("start did not begin warmup");

    idle_stays_a: assert property ((state_q == TRBG_IDLE) && !wr_start |=> state_q == TRBG_IDLE)
        else $error("generator left idle without start");

    stop_halts_a: assert property (wr_stop && state_q != TRBG_IDLE |=> state_q == TRBG_IDLE)
        else $error("stop did not halt");

    warm_exit_a: assert property (state_q == TRBG_WARM && warm_end && !wr_stop |=> state_q == TRBG_RUN)
        else $error("warmup did not end");

    run_only_a: assert property (state_q != TRBG_RUN |-> !byte_done)
        else $error("byte outside run state");

    byte_flag_a: assert property (byte_done |=> flag_q && value_q == $past(next_byte))
        else $error("byte not posted");

    one_event_a: assert property (byte_done |=> !byte_done)
        else $error("two events for one byte");

    value_hold_a: assert property (!byte_done |=> $stable(value_q))
        else $error("value changed without byte");

    raw_take_a: assert property (tick && !cfg_q |-> bit_take)
        else $error("raw bit not taken");

    bc_drop_a: assert property (pair_done && (first_bit_q == noise_q) |-> !bit_take)
        else $error("equal pair not dropped");

    short_stop_a: assert property (byte_done && short_q |=> state_q == TRBG_IDLE)
        else $error("shortcut did not stop");

    short_write_a: assert property (wr_short |=> short_q == $past(wbit))
        else $error("shortcut write lost");

    flag_clear_a: assert property (wr_flag && !wbit && !byte_done |=> !flag_q)
        else $error("flag clear lost");

    set_wins_a: assert property (byte_done && wr_flag |=> flag_q)
        else $error("event lost to software write");

    irq_level_a: assert property (byte_done && ien_q && !wr_iclr |=> irq_o)
        else $error("irq not raised by event");

    ien_set_a: assert property (wr_iset |=> ien_q)
        else $error("enable set failed");

    ien_clear_a: assert property (wr_iclr && !wr_iset |=> !ien_q)
        else $error("enable clear failed");

    cfg_write_a: assert property (wr_cfg |=> cfg_q == $past(wbit))
        else $error("config write lost");

    warm_first_a: assert property ($rose(state_q == TRBG_WARM) |-> !byte_done[*8])
        else $error("byte during warmup");

    ack_once_a: assert property (acc_done |=> !ack_q)
        else $error("access answered twice");

    rdata_hold_a: assert property (acc_done && req.read |-> avs_readdata_o == $past(rsel))
        else $error("read data not from wait cycle");

    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------
    byte_seen_c: cover property (byte_done);
    bc_byte_c:   cover property (byte_done && cfg_q);
    irq_c:       cover property ($rose(irq_o));
    stop_warm_c: cover property (wr_stop && state_q == TRBG_WARM);
    bc_drop_c:   cover property (pair_done && (first_bit_q == noise_q));

endmodule

// [trbg_top_test.sv]
// Purpose: Self-checking bench for the random byte generator registers and events.
// Assumes: Shortened counts START_CYC=200, RAW_BIT_CYC=4, BC_PAIR_CYC=4.
// Notes:   Noise comes from a free-running shift register, so pairs differ often.
`timescale 1ns/1ns
module trbg_top_test;
    import trbg_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        noise_i = 1'b0;
    logic [11:0] avs_address_i = 12'h000;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        irq_o;
    logic [7:0]  lfsr_q = 8'h5a;
    logic [31:0] rd;
    logic [31:0] val;
    logic        hit;
    int          n_mismatch = 0;
    int          n_tests = 0;

    trbg_top #(.START_CYC(200), .RAW_BIT_CYC(4), .BC_PAIR_CYC(4)) u_trbg_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .noise_i(noise_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));

    always #5 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // Noise stimulus
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        lfsr_q  <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        noise_i <= lfsr_q[0];
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        avs_read_i      <= ~wr;
        avs_write_i     <= wr;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic wait_irq(input int lim);
        hit = 1'b0;
        for (int i = 0; i < lim && hit == 1'b0; i++) begin
            @(posedge clk_i);
            if (irq_o === 1'b1) hit = 1'b1;
        end
    endtask

    // ------------------------------------------------------------------
    // Watchdog: the whole sequence needs well under 10000 cycles
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(TRBG_OFS_START, 32'h0000_0000);
        rdchk(TRBG_OFS_FLAG, 32'h0000_0000);
        rdchk(TRBG_OFS_SHORT, 32'h0000_0000);
        rdchk(TRBG_OFS_IRQ_SET, 32'h0000_0000);
        rdchk(TRBG_OFS_CONFIG, 32'h0000_0000);
        rdchk(TRBG_OFS_VALUE, 32'h0000_0000);
        rdchk(12'h010, 32'h0000_0000);
        avs_byteenable_i <= 4'h0;
        wr(TRBG_OFS_CONFIG, 32'h0000_0001);
        avs_byteenable_i <= 4'hf;
        rdchk(TRBG_OFS_CONFIG, 32'h0000_0000);
        $display("test reset_values done");
        // Shortcut: one byte after the warm-up, then the generator halts
        wr(TRBG_OFS_IRQ_SET, 32'h0000_0001);
        rdchk(TRBG_OFS_IRQ_CLR, 32'h0000_0001);
        wr(TRBG_OFS_SHORT, 32'h0000_0001);
        rdchk(TRBG_OFS_SHORT, 32'h0000_0001);
        wr(TRBG_OFS_START, 32'h0000_0001);
        wait_irq(150);
        chk({31'h0, hit}, 32'h0000_0000);
        wait_irq(600);
        chk({31'h0, hit}, 32'h0000_0001);
        rdchk(TRBG_OFS_FLAG, 32'h0000_0001);
        bus(1'b0, TRBG_OFS_VALUE, 32'h0000_0000);
        val = rd;
        chk(val & 32'hffff_ff00, 32'h0000_0000);
        wr(TRBG_OFS_FLAG, 32'h0000_0000);
        @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0000_0000);
        wait_irq(400);
        chk({31'h0, hit}, 32'h0000_0000);
        $display("test shortcut done");
        // Continuous run: no second warm-up between bytes
        wr(TRBG_OFS_SHORT, 32'h0000_0000);
        wr(TRBG_OFS_START, 32'h0000_0001);
        wait_irq(800);
        chk({31'h0, hit}, 32'h0000_0001);
        wr(TRBG_OFS_FLAG, 32'h0000_0000);
        wait_irq(120);
        chk({31'h0, hit}, 32'h0000_0001);
        wr(TRBG_OFS_STOP, 32'h0000_0001);
        wr(TRBG_OFS_FLAG, 32'h0000_0000);
        wait_irq(400);
        chk({31'h0, hit}, 32'h0000_0000);
        $display("test continuous done");
        // Bias correction, then masking while the flag stands
        wr(TRBG_OFS_CONFIG, 32'h0000_0001);
        rdchk(TRBG_OFS_CONFIG, 32'h0000_0001);
        bus(1'b0, TRBG_OFS_VALUE, 32'h0000_0000);
        val = rd;
        wr(TRBG_OFS_VALUE, ~val);
        rdchk(TRBG_OFS_VALUE, val);
        wr(TRBG_OFS_START, 32'h0000_0001);
        wait_irq(2000);
        chk({31'h0, hit}, 32'h0000_0001);
        wr(TRBG_OFS_STOP, 32'h0000_0001);
        wr(TRBG_OFS_IRQ_CLR, 32'h0000_0001);
        rdchk(TRBG_OFS_IRQ_SET, 32'h0000_0000);
        rdchk(TRBG_OFS_FLAG, 32'h0000_0001);
        chk({31'h0, irq_o}, 32'h0000_0000);
        wr(TRBG_OFS_IRQ_SET, 32'h0000_0000);
        rdchk(TRBG_OFS_IRQ_SET, 32'h0000_0000);
        $display("test bias_and_mask done");
        finish_test();
    end
endmodule
